// File: rtl/csamc_top.sv
// carry-select adder chain, pair-sum multiplier and cell register control
`include "csamc_defs.svh"

module csamc_top
    import csamc_pkg::*;
#(
    parameter int NCL = 3,
    parameter bit USE_CHIP_CLEAR = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCL*`CSAMC_CELLS-1:0] opa,
    input wire logic [NCL*`CSAMC_CELLS-1:0] opb,
    input wire logic [1:0] carry_in,
    input wire logic cluster_clock_enable_first,
    input wire logic [NCL-1:0] cluster_clear_n,
    input wire logic [NCL-1:0] preset_or_async_load,
    input wire logic chip_wide_clear_n,
    output logic [NCL*`CSAMC_CELLS-1:0] sum_out,
    output logic [1:0] chain_carry_out,
    output logic [`CSAMC_PROD_W-1:0] fast_span_line,
    output logic [`CSAMC_PROD_W-1:0] product_out
);

    localparam int W = NCL * `CSAMC_CELLS;
    localparam int LAST_EVEN = ((NCL - 1) / 2) * 2;
    localparam int LAST_ODD = (NCL > 1) ? (((NCL - 2) / 2) * 2 + 1) : 0;

    // ****************************************
    // reset combining
    // ****************************************
    logic rst_any;
    assign rst_any = ~presetn | (USE_CHIP_CLEAR & ~chip_wide_clear_n);

    // ****************************************
    // apb slave
    // ****************************************
    logic [`CSAMC_CTRL_W-1:0] ctrl_q;
    logic sclr_q;
    logic sload_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic setup_ph;
    logic access_ph;
    logic wr_ctrl;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_sum;
    logic hit_prod;
    logic mapped;

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_ctrl = paddr == `CSAMC_OFF_CTRL;
    assign hit_stat = paddr == `CSAMC_OFF_STAT;
    assign hit_sum = paddr == `CSAMC_OFF_SUM;
    assign hit_prod = paddr == `CSAMC_OFF_PROD;
    assign mapped = hit_ctrl | hit_stat | hit_sum | hit_prod;
    assign wr_ctrl = access_ph & pwrite & hit_ctrl & clk_en;
    // zero wait states: read data is captured during setup
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or posedge rst_any) begin
        if (rst_any) begin
            ctrl_q <= `CSAMC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[`CSAMC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or posedge rst_any) begin
        if (rst_any) begin
            sclr_q <= 1'b0;
            sload_q <= 1'b0;
        end else if (clk_en) begin
            sclr_q <= wr_ctrl & pwdata[`CSAMC_SCLR_BIT];
            sload_q <= wr_ctrl & pwdata[`CSAMC_SLOAD_BIT];
        end
    end

    always_ff @(posedge pclk or posedge rst_any) begin
        if (rst_any) begin
            prdata_q <= 32'h0000_0000;
        end else if (clk_en & setup_ph) begin
            prdata_q <= rd_mux;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    csamc_mode_t mode;
    logic is_acc;
    logic is_cnt;
    logic is_mul;
    logic sum_reg_sel;
    logic count_up;
    logic span_sel;
    logic mul_pipe;
    logic [NCL-1:0] inv_mask;

    assign mode = csamc_mode_t'(ctrl_q[`CSAMC_MODE_MSB:`CSAMC_MODE_LSB]);
    assign sum_reg_sel = ctrl_q[`CSAMC_SUMREG_BIT];
    assign count_up = ctrl_q[`CSAMC_UPDN_BIT];
    assign span_sel = ctrl_q[`CSAMC_SPAN_BIT];
    assign mul_pipe = ctrl_q[`CSAMC_PIPE_BIT];
    assign inv_mask = ctrl_q[`CSAMC_INV_LSB +: NCL];

    // illegal codes fall back to plain add
    always_comb begin
        is_acc = 1'b0;
        is_cnt = 1'b0;
        is_mul = 1'b0;
        unique case (mode)
            CSAMC_ADD: is_acc = 1'b0;
            CSAMC_ACC: is_acc = 1'b1;
            CSAMC_CNT: is_cnt = 1'b1;
            CSAMC_MUL: is_mul = 1'b1;
            default: is_acc = 1'b0;
        endcase
    end

    // ****************************************
    // adder operand selection
    // ****************************************
    logic [W-1:0] sum_reg_all;
    logic [W-1:0] sum_comb;
    logic [W-1:0] add_x;
    logic [W-1:0] add_y;
    logic [W-1:0] cnt_step;
    logic [1:0] chain_cin;

    // one step at the base of each row chain
    always_comb begin
        cnt_step = '0;
        cnt_step[0] = 1'b1;
        if (NCL > 1) begin
            cnt_step[`CSAMC_CELLS] = 1'b1;
        end
    end

    assign add_x = (is_acc | is_cnt) ? sum_reg_all : opa;
    assign add_y = is_cnt ? (count_up ? cnt_step : '1) : opb;
    assign chain_cin = is_cnt ? 2'h0 : carry_in;

    // ****************************************
    // carry-select look-ahead chain
    // ****************************************
    logic [W-1:0] cin0;
    logic [W-1:0] cin1;
    logic [W-1:0] cout0;
    logic [W-1:0] cout1;
    logic [W-1:0] seg_sel;
    logic [NCL-1:0] lcin;
    logic [NCL-1:0] lmid;
    logic [NCL-1:0] lcout;

    for (genvar p = 0; p < NCL; p++) begin : g_cl
        if (p == 0) begin : g_c0
            assign lcin[p] = chain_cin[0];
        end else if (p == 1) begin : g_c1
            assign lcin[p] = is_mul ? lcout[0] : chain_cin[1];
        end else begin : g_cn
            assign lcin[p] = is_mul ? lcout[p-1] : lcout[p-2];
        end
        assign lmid[p] = lcin[p] ? cout1[p*`CSAMC_CELLS+`CSAMC_GEN_LO]
                                 : cout0[p*`CSAMC_CELLS+`CSAMC_GEN_LO];
        assign lcout[p] = lmid[p] ? cout1[p*`CSAMC_CELLS+`CSAMC_GEN_HI]
                                  : cout0[p*`CSAMC_CELLS+`CSAMC_GEN_HI];

        for (genvar c = 0; c < `CSAMC_CELLS; c++) begin : g_ce
            localparam int I = p * `CSAMC_CELLS + c;
            if (c == 0 || c == `CSAMC_SEG_HI) begin : g_start
                assign cin0[I] = 1'b0;
                assign cin1[I] = 1'b1;
            end else begin : g_link
                assign cin0[I] = cout0[I-1];
                assign cin1[I] = cout1[I-1];
            end
            assign seg_sel[I] = (c < `CSAMC_SEG_HI) ? lcin[p] : lmid[p];
            assign cout0[I] = cin0[I] ? (add_x[I] | add_y[I]) : (add_x[I] & add_y[I]);
            assign cout1[I] = cin1[I] ? (add_x[I] | add_y[I]) : (add_x[I] & add_y[I]);
            assign sum_comb[I] = add_x[I] ^ add_y[I] ^ (seg_sel[I] ? cin1[I] : cin0[I]);
        end
    end

    // ****************************************
    // cell registers
    // ****************************************
    logic [NCL-1:0] cell_clr;
    logic [NCL-1:0] cell_pre;
    logic sum_en;

    assign sum_en = clk_en & cluster_clock_enable_first & ~is_mul;

    for (genvar p = 0; p < NCL; p++) begin : g_reg
        logic [`CSAMC_CELLS-1:0] seg_q;
        logic [`CSAMC_CELLS-1:0] inv_v;
        assign inv_v = {`CSAMC_CELLS{inv_mask[p]}};
        assign cell_clr[p] = rst_any | ~cluster_clear_n[p];
        // preset borrowed in multiplier mode; keep mode static while preset is high
        assign cell_pre[p] = preset_or_async_load[p] & ~is_mul;
        assign sum_reg_all[p*`CSAMC_CELLS +: `CSAMC_CELLS] = seg_q ^ inv_v;

        always_ff @(posedge pclk or posedge cell_clr[p] or posedge cell_pre[p]) begin
            if (cell_clr[p]) begin
                seg_q <= '0;
            end else if (cell_pre[p]) begin
                seg_q <= '1;
            end else if (sum_en) begin
                if (sclr_q) begin
                    seg_q <= inv_v;
                end else if (sload_q) begin
                    seg_q <= opa[p*`CSAMC_CELLS +: `CSAMC_CELLS] ^ inv_v;
                end else begin
                    seg_q <= sum_comb[p*`CSAMC_CELLS +: `CSAMC_CELLS] ^ inv_v;
                end
            end
        end
    end

    assign sum_out = sum_reg_sel ? sum_reg_all : sum_comb;

    logic [1:0] chain_q;
    always_ff @(posedge pclk or posedge rst_any) begin
        if (rst_any) begin
            chain_q <= 2'h0;
        end else if (clk_en) begin
            chain_q[0] <= is_mul ? lcout[NCL-1] : lcout[LAST_EVEN];
            chain_q[1] <= (is_mul || NCL < 2) ? 1'b0 : lcout[LAST_ODD];
        end
    end
    assign chain_carry_out = chain_q;

    // ****************************************
    // multiplier
    // ****************************************
    logic [`CSAMC_MUL_W-1:0] ma;
    logic [`CSAMC_MUL_W-1:0] mb;
    logic [`CSAMC_PAIR_W-1:0] pair_w [`CSAMC_PAIRS];
    logic [`CSAMC_PAIR_W-1:0] pair_q [`CSAMC_PAIRS];
    logic [`CSAMC_PAIR_W-1:0] pair_use [`CSAMC_PAIRS];
    logic mul_adv;
    logic [1:0] mcell_cout;

    assign ma = opa[`CSAMC_MUL_W-1:0];
    assign mb = opb[`CSAMC_MUL_W-1:0];
    assign mul_adv = clk_en & is_mul & cluster_clock_enable_first;

    for (genvar k = 0; k < `CSAMC_PAIRS; k++) begin : g_pair
        logic [`CSAMC_MUL_W-1:0] pp_lo;
        logic [`CSAMC_MUL_W-1:0] pp_hi;
        assign pp_lo = ma & {`CSAMC_MUL_W{mb[2*k]}};
        assign pp_hi = ma & {`CSAMC_MUL_W{mb[2*k+1]}};
        assign pair_w[k] = {2'b00, pp_lo} + {1'b0, pp_hi, 1'b0};
        always_ff @(posedge pclk or posedge rst_any) begin
            if (rst_any) begin
                pair_q[k] <= '0;
            end else if (mul_adv) begin
                pair_q[k] <= pair_w[k];
            end
        end
        assign pair_use[k] = mul_pipe ? pair_q[k] : pair_w[k];
    end

    // top column cell carries, terms a[14]b[1] and a[15]b[0]
    assign mcell_cout[0] = ma[`CSAMC_MUL_W-2] & mb[1] & ma[`CSAMC_MUL_W-1] & mb[0];
    assign mcell_cout[1] = (ma[`CSAMC_MUL_W-2] & mb[1]) | (ma[`CSAMC_MUL_W-1] & mb[0]);

    logic [`CSAMC_PROD_W-1:0] lvl1 [4];
    logic [`CSAMC_PROD_W-1:0] lvl2 [2];
    logic [`CSAMC_PROD_W-1:0] prod_w;

    always_comb begin
        for (int j = 0; j < 4; j++) begin
            lvl1[j] = {14'h0000, pair_use[2*j]} + ({14'h0000, pair_use[2*j+1]} << 2);
        end
        for (int j = 0; j < 2; j++) begin
            lvl2[j] = lvl1[2*j] + (lvl1[2*j+1] << 4);
        end
        prod_w = lvl2[0] + (lvl2[1] << 8);
    end

    logic [`CSAMC_PROD_W-1:0] span_q;
    logic [`CSAMC_PROD_W-1:0] local_q;
    logic [1:0] mcout_q;

    // one path only; preset line high holds the product
    always_ff @(posedge pclk or posedge rst_any) begin
        if (rst_any) begin
            span_q <= '0;
            local_q <= '0;
            mcout_q <= 2'h0;
        end else if (mul_adv & ~preset_or_async_load[0]) begin
            span_q <= span_sel ? prod_w : '0;
            local_q <= span_sel ? '0 : prod_w;
            mcout_q <= mcell_cout;
        end
    end
    assign fast_span_line = span_q;
    assign product_out = local_q;

    // ****************************************
    // read mux
    // ****************************************
    logic [31:0] stat_v;
    logic [31:0] sum_v;
    logic local_ok;

    assign local_ok = ~(is_mul & span_sel);
    assign stat_v = {28'h0000000, mcout_q, chain_q};
    assign sum_v = local_ok ? 32'(sum_reg_all) : 32'h0000_0000;
    assign rd_mux = hit_ctrl ? {16'h0000, ctrl_q} :
                    hit_stat ? stat_v :
                    hit_sum ? sum_v :
                    hit_prod ? local_q : 32'h0000_0000;

endmodule : csamc_top

// File: rtl/csamc_defs.svh
// constants for the carry-select adder and multiplier cell block
`ifndef CSAMC_DEFS_SVH
`define CSAMC_DEFS_SVH

// ****************************************
// cluster geometry
// ****************************************
`define CSAMC_CELLS 10
`define CSAMC_GEN_LO 3
`define CSAMC_GEN_HI 9
`define CSAMC_SEG_HI 4
`define CSAMC_MUL_W 16
`define CSAMC_PAIRS 8
`define CSAMC_PAIR_W 18
`define CSAMC_PROD_W 32

// ****************************************
// register offsets
// ****************************************
`define CSAMC_OFF_CTRL 12'h000
`define CSAMC_OFF_STAT 12'h004
`define CSAMC_OFF_SUM 12'h008
`define CSAMC_OFF_PROD 12'h00C

// ****************************************
// control fields and reset values
// ****************************************
`define CSAMC_MODE_LSB 0
`define CSAMC_MODE_MSB 3
`define CSAMC_SUMREG_BIT 4
`define CSAMC_UPDN_BIT 5
`define CSAMC_SPAN_BIT 6
`define CSAMC_PIPE_BIT 7
`define CSAMC_INV_LSB 8
`define CSAMC_INV_MSB 15
`define CSAMC_SCLR_BIT 16
`define CSAMC_SLOAD_BIT 17
`define CSAMC_CTRL_RST 16'h0001
`define CSAMC_CTRL_W 16

`endif

// File: rtl/csamc_pkg.sv
// types shared by the carry-select adder and multiplier cell block
package csamc_pkg;

    // ****************************************
    // operating modes, one-hot
    // ****************************************
    typedef enum logic [3:0] {
        CSAMC_ADD = 4'h1,
        CSAMC_ACC = 4'h2,
        CSAMC_CNT = 4'h4,
        CSAMC_MUL = 4'h8
    } csamc_mode_t;

endpackage : csamc_pkg

// File: test/csamc_chk.sv
// port assertions for the cell block
`include "csamc_defs.svh"
module csamc_chk #(
    parameter int NCL = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cluster_clock_enable_first,
    input wire logic [NCL-1:0] preset_or_async_load,
    input wire logic chip_wide_clear_n,
    input wire logic [1:0] chain_carry_out,
    input wire logic [`CSAMC_PROD_W-1:0] fast_span_line,
    input wire logic [`CSAMC_PROD_W-1:0] product_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire acc = psel && penable;
    wire mapped = paddr inside {`CSAMC_OFF_CTRL, `CSAMC_OFF_STAT, `CSAMC_OFF_SUM, `CSAMC_OFF_PROD};
    wire hold = preset_or_async_load[0] || !cluster_clock_enable_first;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****
    // assertions
    // ****
    ready_access_a: assert property (acc |-> pready) else $error("access not ready");
    err_unmapped_a: assert property (acc && !mapped |-> pslverr) else $error("hole not refused");
    err_mapped_a: assert property (pslverr |-> acc && !mapped) else $error("stray error");
    chip_clear_a: assert property (!chip_wide_clear_n |->
        product_out == 0 && fast_span_line == 0 && chain_carry_out == 0 && prdata == 0)
        else $error("chip clear left state");
    span_excl_a: assert property (fast_span_line != 0 |-> product_out == 0)
        else $error("both product paths driven");
    freeze_out_a: assert property (!clk_en && chip_wide_clear_n ##1 chip_wide_clear_n
        |-> $stable(product_out) && $stable(chain_carry_out)) else $error("moved while frozen");
    freeze_bus_a: assert property (!clk_en ##1 chip_wide_clear_n |-> $stable(prdata))
        else $error("read data moved while frozen");
    hold_prod_a: assert property (hold && chip_wide_clear_n ##1 chip_wide_clear_n
        |-> $stable(product_out | fast_span_line)) else $error("product moved on hold");
    cover property (acc && pslverr);
    cover property (fast_span_line != 0);
    cover property (chain_carry_out == 2'h3);
endmodule : csamc_chk

bind csamc_top csamc_chk #(.NCL(NCL)) i_chk (.*);

// File: test/csamc_user.sv
// operand source standing for the surrounding user logic
module csamc_user #(
    parameter int W = 30
) (
    input wire logic pclk,
    input wire logic req,
    input wire logic slow,
    input wire logic [W-1:0] a_in,
    input wire logic [W-1:0] b_in,
    input wire logic [1:0] c_in,
    output logic [W-1:0] opa,
    output logic [W-1:0] opb,
    output logic [1:0] carry_in,
    output logic ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic late_q = 1'b0;
    initial begin
        opa = '0;
        opb = '0;
        carry_in = '0;
        ack = 1'b0;
    end
    // operands only, cluster enable left alone
    always @(posedge pclk) begin
        ack <= 1'b0;
        late_q <= 1'b0;
        if (req && !ack && slow && !late_q) begin
            late_q <= 1'b1;
        end else if (req && !ack) begin
            opa <= a_in;
            opb <= b_in;
            carry_in <= c_in;
            ack <= 1'b1;
        end
    end
endmodule : csamc_user

// File: test/csamc_top_tb.sv
// self-checking bench for the cell block
`include "csamc_defs.svh"
module csamc_top_tb
    import csamc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCL = 3;
    localparam int W = NCL * `CSAMC_CELLS;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, req = 1'b0, slow = 1'b0, ack, er;
    logic cluster_clock_enable_first = 1'b0, chip_wide_clear_n = 1'b1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, e, fast_span_line, product_out;
    logic [W-1:0] a_in = '0, b_in = '0, opa, opb, sum_out, m, x, y;
    logic [1:0] c_in = '0, carry_in, chain_carry_out;
    logic [NCL-1:0] cluster_clear_n = '1, preset_or_async_load = '0;
    int fails = 0, checks = 0, cyc = 0;
    csamc_top #(.NCL(NCL)) i_dut (.*);
    csamc_user #(.W(W)) i_user (.*);
    initial begin
        forever #10 pclk = ~pclk;
    end
    // ****
    // model and tasks
    // ****
    function automatic logic [31:0] add_m(input logic [W-1:0] a, b, input logic [1:0] c);
        int ev, od;
        ev = int'({a[29:20], a[9:0]}) + int'({b[29:20], b[9:0]}) + int'(c[0]);
        od = int'(a[19:10]) + int'(b[19:10]) + int'(c[1]);
        return {od[10], ev[20], ev[19:10], od[9:0], ev[9:0]};
    endfunction : add_m
    task automatic check(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask : tick
    task automatic step();
        @(posedge pclk);
        cluster_clock_enable_first <= 1'b1;
        @(posedge pclk);
        cluster_clock_enable_first <= 1'b0;
        #1;
    endtask : step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the cycle timeout ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ops(input logic [W-1:0] a, b, input logic [1:0] c);
        @(posedge pclk);
        a_in <= a;
        b_in <= b;
        c_in <= c;
        slow <= 1'($urandom % 2);
        req <= 1'b1;
        do begin
            @(posedge pclk);
        end while (ack !== 1'b1);
        req <= 1'b0;
    endtask : ops
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            finish_test();
        end
    end
    // ****
    // scenarios
    // ****
    initial begin
        void'($urandom(88871));
        tick(16);
        presetn <= 1'b1;
        apb(1'b0, `CSAMC_OFF_CTRL, 32'h0);
        check(rd, 32'(`CSAMC_CTRL_RST));
        apb(1'b0, 12'h010, 32'h0);
        check({rd[30:0], er}, 32'h1);
        cluster_clock_enable_first <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            x = (i == 3) ? '1 : W'($urandom);
            y = (i == 3) ? '0 : W'($urandom);
            e = add_m(x, y, 2'(i));
            ops(x, y, 2'(i));
            tick(2);
            #1;
            check(32'(sum_out), e & 32'h3FFFFFFF);
            check(32'(chain_carry_out), e >> 30);
        end
        apb(1'b1, `CSAMC_OFF_CTRL, 32'h12);
        cluster_clock_enable_first <= 1'b0;
        cluster_clear_n <= '0;
        tick(1);
        cluster_clear_n <= '1;
        m = '0;
        for (int i = 0; i < 5; i++) begin
            y = W'($urandom);
            ops(W'($urandom), y, 2'b00);
            if (i == 4) clk_en <= 1'b0;
            step();
            if (i < 4) m = W'(add_m(m, y, 2'b00));
            check(32'(sum_out), 32'(m));
        end
        tick(1);
        clk_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            x = W'($urandom);
            ops(x, W'($urandom) | W'(1), 2'b00);
            cluster_clock_enable_first <= 1'b1;
            apb(1'b1, `CSAMC_OFF_CTRL, 32'h11 | (32'h1 << (`CSAMC_SCLR_BIT + k)));
            tick(1);
            cluster_clock_enable_first <= 1'b0;
            #1;
            check(32'(sum_out), (k == 1) ? 32'(x) : 32'h0);
        end
        apb(1'b1, `CSAMC_OFF_CTRL, 32'h211);
        preset_or_async_load <= '1;
        tick(1);
        #1;
        check(32'(sum_out), 32'h3FF003FF);
        tick(1);
        cluster_clear_n <= '0;
        tick(1);
        #1;
        check(32'(sum_out), 32'h000FFC00);
        tick(1);
        cluster_clear_n <= '1;
        preset_or_async_load <= '0;
        apb(1'b1, `CSAMC_OFF_CTRL, 32'h34);
        step();
        check(32'(sum_out), add_m('0, W'(12'h401), 2'b00));
        apb(1'b1, `CSAMC_OFF_CTRL, 32'h14);
        m = W'(12'h401);
        for (int i = 0; i < 2; i++) begin
            step();
            m = W'(add_m(m, '1, 2'b00));
            check(32'(sum_out), 32'(m));
        end
        apb(1'b0, `CSAMC_OFF_SUM, 32'h0);
        check(rd, 32'(m));
        apb(1'b1, `CSAMC_OFF_CTRL, 32'(CSAMC_MUL));
        cluster_clock_enable_first <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            x = (i == 0) ? '1 : W'($urandom);
            y = (i == 0) ? '1 : W'($urandom);
            e = 32'(x[15:0]) * 32'(y[15:0]);
            ops(x, y, 2'b00);
            #1;
            check(product_out, e);
            check(fast_span_line, 32'h0);
        end
        apb(1'b0, `CSAMC_OFF_PROD, 32'h0);
        check(rd, e);
        apb(1'b1, `CSAMC_OFF_CTRL, 32'h88);
        x = ~x;
        y = ~y;
        ops(x, y, 2'b00);
        #1;
        check(product_out, e);
        tick(1);
        #1;
        e = 32'(x[15:0]) * 32'(y[15:0]);
        check(product_out, e);
        apb(1'b1, `CSAMC_OFF_CTRL, 32'h48);
        tick(1);
        #1;
        check(fast_span_line, e);
        check(product_out, 32'h0);
        apb(1'b0, `CSAMC_OFF_STAT, 32'h0);
        m = W'({(x[14] & y[1]) | (x[15] & y[0]), x[14] & y[1] & x[15] & y[0], 1'b0,
            1'(({1'b0, x} + {1'b0, y}) >> 30)});
        check(rd, 32'(m));
        apb(1'b0, `CSAMC_OFF_SUM, 32'h0);
        check(rd, 32'h0);
        tick(1);
        preset_or_async_load <= 3'b001;
        ops(~x, y, 2'b00);
        tick(1);
        #1;
        check(fast_span_line, e);
        tick(1);
        preset_or_async_load <= '0;
        chip_wide_clear_n <= 1'b0;
        tick(2);
        #1;
        check(fast_span_line | product_out | 32'(chain_carry_out), 32'h0);
        tick(1);
        chip_wide_clear_n <= 1'b1;
        apb(1'b0, `CSAMC_OFF_CTRL, 32'h0);
        check(rd, 32'(`CSAMC_CTRL_RST));
        finish_test();
    end
endmodule : csamc_top_tb
